//--- core/pipc_ctrl.sv
// Peripheral interrupt priority controller with APB register slave
// Operation
// [R01] Second enable register gates its six sources
// [R02] Third enable register gates its six sources
// [R03] Unimplemented bits always read as zero
// [R04] Priority bit one means high, zero low
// [R05] Priority bits act only with levels enabled
// [R06] First priority register: eight peripheral sources
// [R07] Second priority bits mirror second enable
// [R08] Third priority bits mirror third enable
// [R09] Levels enable bit selects two-level or single
// [R10] Reset-cause flags in reset control register
// [R11] External pins edge-triggered, edge selectable
// [R12] Valid edge sets flag; enable gates request
// [R13] Software clears flag before re-enabling
// [R14] Enabled external interrupt wakes from sleep
// [R15] Branch after wake only when globally enabled
// [R16] External pin priorities; pin zero always high
// [R17] Timer-zero overflow sets its flag
// [R18] Timer-zero enable and priority bits
// [R19] Port-B high nibble change sets flag
// [R20] Interrupt take pushes PC, saves context
// [R21] Software saves context without fast return
// [R22] Single-level peripherals need group enable
// [R23] Flag and enable route to a level
`timescale 1ns/1ps
module pipc_ctrl (
   input logic clock_in,              // Core clock, 200 MHz
   input logic srst_in,               // Synchronous reset, active high
   input logic psel_in,               // APB select
   input logic penable_in,            // APB enable
   input logic pwrite_in,             // APB direction, 1 = write
   input logic [11:0] paddr_in,       // APB byte address
   input logic [31:0] pwdata_in,      // APB write data
   output logic [31:0] prdata_out,    // APB read data
   output logic pready_out,           // APB ready
   output logic pslverr_out,          // APB error on unmapped address
   input logic [7:0] periph_flag_one_in,   // First peripheral flags
   input logic [7:0] periph_flag_two_in,   // Second peripheral flags
   input logic [7:0] periph_flag_three_in, // Third peripheral flags
   input logic [7:0] periph_enable_one_in, // First peripheral enables
   input logic [3:0] ext_pin_in,      // External interrupt pins 3..0
   input logic [3:0] portb_high_in,   // Port-B bits 7:4
   input logic sleep_in,              // Core is asleep
   input logic reset_instr_evt_in,    // Reset instruction executed
   input logic watchdog_evt_in,       // Watchdog timeout
   input logic power_down_evt_in,     // Sleep instruction executed
   input logic irq_ack_in,            // Core takes an interrupt
   input logic [20:0] ret_pc_in,      // Return program counter
   input logic [7:0] working_in,      // Working register
   input logic [7:0] status_in,       // Status register
   input logic [7:0] bank_in,         // Bank-select register
   output logic irq_high_out,         // High-level request
   output logic irq_low_out,          // Low-level request
   output logic wake_out,             // Wake request from sleep
   output logic stack_push_out,       // Hardware stack push strobe
   output logic [20:0] stack_pc_out,  // Pushed return address
   output logic [7:0] fast_working_out, // Fast stack working copy
   output logic [7:0] fast_status_out,  // Fast stack status copy
   output logic [7:0] fast_bank_out     // Fast stack bank copy
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] en_two;
      logic [7:0] en_three;
      logic [7:0] prio_one;
      logic [7:0] prio_two;
      logic [7:0] prio_three;
      logic [7:0] reset_cause_and_priority_ctrl;
      logic [7:0] main_ctl;
      logic [7:0] ctl_two;
      logic [7:0] ctl_three;
      logic [1:0] t0_ctl;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq_high;
      logic irq_low;
      logic wake;
      logic push;
      logic [20:0] push_pc;
      logic [7:0] fast_working;
      logic [7:0] fast_status;
      logic [7:0] fast_bank;
   } pipc_state_s;

   pipc_state_s q;
   pipc_state_s d;

   logic [3:0] ext_lvl;
   logic [3:0] ext_prev;
   logic [3:0] rb_lvl;
   logic [3:0] rb_prev;
   logic [3:0] ext_set;
   logic [3:0] ext_en;
   logic [3:0] ext_flag;
   logic [3:0] ext_prio;
   logic rb_chg;
   logic [15:0] t0_count;
   logic t0_ovf;
   logic t0_load;
   logic acc_done;
   logic wr_en;
   logic priority_levels_enable;
   logic [32:0] rd;
   logic [7:0] pend_one;
   logic [7:0] pend_two;
   logic [7:0] pend_three;
   logic [5:0] core_pend;
   logic [5:0] core_prio;
   logic periph_hi;
   logic periph_lo;
   logic periph_any;
   logic core_hi;
   logic core_lo;
   logic core_any;

   // ---------------------------------------------------------------
   // Register read decode
   // ---------------------------------------------------------------
   function automatic logic [32:0] reg_read(input logic [11:0] a, input pipc_state_s s,
                                           input logic [15:0] cnt);
      logic [32:0] r;
      r = '0;
      case (a)
         pipc_pkg::OFF_EN_TWO: r = {1'b1, 24'h0, s.en_two & pipc_pkg::MASK_TWO}; // R03
         pipc_pkg::OFF_EN_THREE: r = {1'b1, 24'h0, s.en_three & pipc_pkg::MASK_THREE};
         pipc_pkg::OFF_PRIO_ONE: r = {1'b1, 24'h0, s.prio_one};
         pipc_pkg::OFF_PRIO_TWO: r = {1'b1, 24'h0, s.prio_two & pipc_pkg::MASK_TWO};
         pipc_pkg::OFF_PRIO_THREE: r = {1'b1, 24'h0, s.prio_three & pipc_pkg::MASK_THREE};
         pipc_pkg::OFF_RESET_CTL: r = {1'b1, 24'h0, s.reset_cause_and_priority_ctrl & pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_RD_MASK}; // R10
         pipc_pkg::OFF_MAIN_CTL: r = {1'b1, 24'h0, s.main_ctl};
         pipc_pkg::OFF_CTL_TWO: r = {1'b1, 24'h0, s.ctl_two & pipc_pkg::MASK_CTL_TWO};
         pipc_pkg::OFF_CTL_THREE: r = {1'b1, 24'h0, s.ctl_three};
         pipc_pkg::OFF_T0_CTL: r = {1'b1, 30'h0, s.t0_ctl};
         pipc_pkg::OFF_T0_CNT: r = {1'b1, 16'h0, cnt};
         default: r = '0;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers and timer
   // ---------------------------------------------------------------
   pipc_sync #(.WIDTH(4)) ext_sync (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .async_in(ext_pin_in),
      .level_out(ext_lvl),
      .prev_out(ext_prev)
   );

   pipc_sync #(.WIDTH(4)) rb_sync (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .async_in(portb_high_in),
      .level_out(rb_lvl),
      .prev_out(rb_prev)
   );

   pipc_timer_zero timer_zero (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .run_in(q.t0_ctl[pipc_pkg::T0_RUN]),
      .mode16_in(q.t0_ctl[pipc_pkg::T0_MODE16]),
      .load_in(t0_load),
      .load_val_in(pwdata_in[15:0]),
      .count_out(t0_count),
      .ovf_out(t0_ovf)
   );

   // ---------------------------------------------------------------
   // Edge detection per external pin
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         assign ext_set[gi] = q.ctl_two[pipc_pkg::CTL2_EDGE_LSB + gi] ?
                              (ext_lvl[gi] & ~ext_prev[gi]) :
                              (~ext_lvl[gi] & ext_prev[gi]); // R11
      end
   endgenerate

   assign rb_chg = |(rb_lvl ^ rb_prev); // R19

   // ---------------------------------------------------------------
   // Request routing
   // ---------------------------------------------------------------
   always_comb begin
      priority_levels_enable = q.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_PRIORITY_LEVELS_ENABLE]; // R09
      ext_en = {q.ctl_three[pipc_pkg::CTL3_EN_LSB +: 3], q.main_ctl[pipc_pkg::MAIN_INT0E]};
      ext_flag = {q.ctl_three[pipc_pkg::CTL3_FLAG_LSB +: 3], q.main_ctl[pipc_pkg::MAIN_INT0F]};
      ext_prio = {q.ctl_two[pipc_pkg::CTL2_INT3P], q.ctl_three[pipc_pkg::CTL3_INT2P],
                  q.ctl_three[pipc_pkg::CTL3_INT1P], 1'b1}; // R16
      pend_one = periph_flag_one_in & periph_enable_one_in; // R23
      pend_two = periph_flag_two_in & q.en_two & pipc_pkg::MASK_TWO; // R01
      pend_three = periph_flag_three_in & q.en_three & pipc_pkg::MASK_THREE; // R02
      core_pend = {ext_flag & ext_en,
                   q.main_ctl[pipc_pkg::MAIN_T0F] & q.main_ctl[pipc_pkg::MAIN_T0E], // R18
                   q.main_ctl[pipc_pkg::MAIN_RBF] & q.main_ctl[pipc_pkg::MAIN_RBE]}; // R19
      core_prio = {ext_prio, q.ctl_two[pipc_pkg::CTL2_T0P], q.ctl_two[pipc_pkg::CTL2_RBP]};
      periph_hi = |(pend_one & q.prio_one) | |(pend_two & q.prio_two)
                  | |(pend_three & q.prio_three); // R04 R06 R07 R08
      periph_lo = |(pend_one & ~q.prio_one) | |(pend_two & ~q.prio_two)
                  | |(pend_three & ~q.prio_three);
      periph_any = |pend_one | |pend_two | |pend_three;
      core_hi = |(core_pend & core_prio);
      core_lo = |(core_pend & ~core_prio);
      core_any = |core_pend;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      acc_done = psel_in & penable_in & q.pready;
      wr_en = acc_done & pwrite_in & ~q.pslverr;
      rd = reg_read(paddr_in, q, t0_count);
      t0_load = wr_en & (paddr_in == pipc_pkg::OFF_T0_CNT);

      // Bus slave: answer prepared in setup, released after access
      if (psel_in & ~penable_in) begin
         d.prdata = rd[31:0];
         d.pready = 1'b1;
         d.pslverr = ~rd[32];
      end else if (acc_done) begin
         d.prdata = '0;
         d.pready = 1'b0;
         d.pslverr = 1'b0;
      end

      if (wr_en) begin
         case (paddr_in)
            pipc_pkg::OFF_EN_TWO: d.en_two = pwdata_in[7:0] & pipc_pkg::MASK_TWO; // R01 R03
            pipc_pkg::OFF_EN_THREE: d.en_three = pwdata_in[7:0] & pipc_pkg::MASK_THREE; // R02
            pipc_pkg::OFF_PRIO_ONE: d.prio_one = pwdata_in[7:0]; // R06
            pipc_pkg::OFF_PRIO_TWO: d.prio_two = pwdata_in[7:0] & pipc_pkg::MASK_TWO; // R07
            pipc_pkg::OFF_PRIO_THREE: d.prio_three = pwdata_in[7:0] & pipc_pkg::MASK_THREE; // R08
            pipc_pkg::OFF_RESET_CTL: d.reset_cause_and_priority_ctrl = (q.reset_cause_and_priority_ctrl & ~pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_WR_MASK)
                                            | (pwdata_in[7:0] & pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_WR_MASK);
            pipc_pkg::OFF_MAIN_CTL: d.main_ctl = pwdata_in[7:0];
            pipc_pkg::OFF_CTL_TWO: d.ctl_two = pwdata_in[7:0] & pipc_pkg::MASK_CTL_TWO;
            pipc_pkg::OFF_CTL_THREE: d.ctl_three = pwdata_in[7:0];
            pipc_pkg::OFF_T0_CTL: d.t0_ctl = pwdata_in[1:0];
            default: d.t0_ctl = q.t0_ctl;
         endcase
      end

      // Hardware events win over a clearing write in the same cycle
      if (ext_set[0]) begin
         d.main_ctl[pipc_pkg::MAIN_INT0F] = 1'b1; // R12
      end
      d.ctl_three[pipc_pkg::CTL3_FLAG_LSB +: 3] = d.ctl_three[pipc_pkg::CTL3_FLAG_LSB +: 3]
                                                 | ext_set[3:1]; // R12
      if (t0_ovf) begin
         d.main_ctl[pipc_pkg::MAIN_T0F] = 1'b1; // R17
      end
      if (rb_chg) begin
         d.main_ctl[pipc_pkg::MAIN_RBF] = 1'b1; // R19
      end
      if (reset_instr_evt_in) begin
         d.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_RI] = 1'b0; // R10
      end
      if (watchdog_evt_in) begin
         d.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_TO] = 1'b0;
      end
      if (power_down_evt_in) begin
         d.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_PD] = 1'b0;
      end

      // Two-level mode uses the global bit as high and group bit as low enable
      if (priority_levels_enable) begin
         d.irq_high = q.main_ctl[pipc_pkg::MAIN_GIE] & (periph_hi | core_hi); // R05 R23
         d.irq_low = q.main_ctl[pipc_pkg::MAIN_GIE] & q.main_ctl[pipc_pkg::MAIN_PERIPH_GROUP_ENABLE]
                     & (periph_lo | core_lo);
      end else begin
         d.irq_high = q.main_ctl[pipc_pkg::MAIN_GIE]
                      & (core_any | (q.main_ctl[pipc_pkg::MAIN_PERIPH_GROUP_ENABLE] & periph_any)); // R22
         d.irq_low = 1'b0; // R05
      end

      // Wake does not depend on the global enable; vectoring does
      d.wake = sleep_in & |(ext_flag & ext_en); // R14 R15

      d.push = irq_ack_in; // R20
      if (irq_ack_in) begin
         d.push_pc = ret_pc_in;
         d.fast_working = working_in;
         d.fast_status = status_in;
         d.fast_bank = bank_in;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         q <= '0;
         q.en_two <= pipc_pkg::RST_EN;
         q.en_three <= pipc_pkg::RST_EN;
         q.prio_one <= pipc_pkg::RST_PRIO_ONE;
         q.prio_two <= pipc_pkg::RST_PRIO_TWO;
         q.prio_three <= pipc_pkg::RST_PRIO_THREE;
         q.reset_cause_and_priority_ctrl <= pipc_pkg::RST_RESET_CTL;
         q.main_ctl <= pipc_pkg::RST_MAIN_CTL;
         q.ctl_two <= pipc_pkg::RST_CTL_TWO;
         q.ctl_three <= pipc_pkg::RST_CTL_THREE;
         q.t0_ctl <= pipc_pkg::RST_T0_CTL;
      end else begin
         q <= d;
      end
   end

   assign prdata_out = q.prdata;
   assign pready_out = q.pready;
   assign pslverr_out = q.pslverr;
   assign irq_high_out = q.irq_high;
   assign irq_low_out = q.irq_low;
   assign wake_out = q.wake;
   assign stack_push_out = q.push;
   assign stack_pc_out = q.push_pc;
   assign fast_working_out = q.fast_working;
   assign fast_status_out = q.fast_status;
   assign fast_bank_out = q.fast_bank;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (srst_in);

   unimpl_bits_a: assert property ( // R03
      ((q.en_two | q.prio_two) & ~pipc_pkg::MASK_TWO) == 8'h00
      && ((q.en_three | q.prio_three) & ~pipc_pkg::MASK_THREE) == 8'h00
   ) else $error("Unimplemented enable or priority bit set");

   reset_cause_and_priority_ctrl_gap_a: assert property ( // R10
      psel_in && !penable_in && paddr_in == pipc_pkg::OFF_RESET_CTL
      |=> prdata_out[6:5] == 2'h0 && prdata_out[31:8] == 24'h0
   ) else $error("Reset control gap bits read nonzero");

   single_level_a: assert property ( // R05
      !q.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_PRIORITY_LEVELS_ENABLE] |=> !irq_low_out
   ) else $error("Low request raised in single-level mode");

   ext_edge_a: assert property ( // R12
      ext_set[0] |=> q.main_ctl[pipc_pkg::MAIN_INT0F]
   ) else $error("External pin zero edge did not set its flag");

   ext_zero_high_a: assert property ( // R16
      q.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_PRIORITY_LEVELS_ENABLE] && q.main_ctl[pipc_pkg::MAIN_GIE] && core_pend[2]
      |=> irq_high_out
   ) else $error("External pin zero not routed high");

   timer_flag_a: assert property ( // R17
      t0_ovf |=> q.main_ctl[pipc_pkg::MAIN_T0F]
   ) else $error("Timer-zero overflow lost");

   portb_flag_a: assert property ( // R19
      rb_lvl != rb_prev |=> q.main_ctl[pipc_pkg::MAIN_RBF]
   ) else $error("Port-B change lost");

   group_gate_a: assert property ( // R22
      !q.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_PRIORITY_LEVELS_ENABLE] && !q.main_ctl[pipc_pkg::MAIN_PERIPH_GROUP_ENABLE] && !core_any
      |=> !irq_high_out
   ) else $error("Peripheral request passed without group enable");

   periph_two_a: assert property ( // R01
      !q.reset_cause_and_priority_ctrl[pipc_pkg::RESET_CAUSE_AND_PRIORITY_CTRL_PRIORITY_LEVELS_ENABLE] && q.main_ctl[pipc_pkg::MAIN_GIE]
      && q.main_ctl[pipc_pkg::MAIN_PERIPH_GROUP_ENABLE] && (periph_flag_two_in & q.en_two) != 8'h00
      |=> irq_high_out
   ) else $error("Enabled second-group request not delivered");

   wake_ext_a: assert property ( // R14
      sleep_in && ext_flag[0] && ext_en[0] |=> wake_out
   ) else $error("Enabled external interrupt did not wake");

   push_ctx_a: assert property ( // R20
      irq_ack_in |=> stack_push_out && stack_pc_out == $past(ret_pc_in)
      && fast_bank_out == $past(bank_in) ##1 !stack_push_out || $past(irq_ack_in)
   ) else $error("Context not saved on interrupt take");

endmodule

//--- core/pipc_pkg.sv
// Package of offsets, field positions and reset values for the interrupt priority controller
package pipc_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PC_W = 21;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFF_EN_TWO = 12'h000;
   localparam logic [11:0] OFF_EN_THREE = 12'h004;
   localparam logic [11:0] OFF_PRIO_ONE = 12'h008;
   localparam logic [11:0] OFF_PRIO_TWO = 12'h00c;
   localparam logic [11:0] OFF_PRIO_THREE = 12'h010;
   localparam logic [11:0] OFF_RESET_CTL = 12'h014;
   localparam logic [11:0] OFF_MAIN_CTL = 12'h018;
   localparam logic [11:0] OFF_CTL_TWO = 12'h01c;
   localparam logic [11:0] OFF_CTL_THREE = 12'h020;
   localparam logic [11:0] OFF_T0_CTL = 12'h024;
   localparam logic [11:0] OFF_T0_CNT = 12'h028;

   // ---------------------------------------------------------------
   // Implemented-bit masks and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MASK_TWO = 8'h5f;
   localparam logic [7:0] MASK_THREE = 8'h3f;
   localparam logic [7:0] MASK_ONE = 8'hff;
   localparam logic [7:0] RST_EN = 8'h00;
   localparam logic [7:0] RST_PRIO_ONE = 8'hff;
   localparam logic [7:0] RST_PRIO_TWO = 8'h5f;
   localparam logic [7:0] RST_PRIO_THREE = 8'h3f;
   localparam logic [7:0] RST_RESET_CTL = 8'h1c;
   localparam logic [7:0] RESET_CAUSE_AND_PRIORITY_CTRL_RD_MASK = 8'h9f;
   localparam logic [7:0] RESET_CAUSE_AND_PRIORITY_CTRL_WR_MASK = 8'h93;
   localparam logic [7:0] RST_MAIN_CTL = 8'h00;
   localparam logic [7:0] RST_CTL_TWO = 8'h7f;
   localparam logic [7:0] MASK_CTL_TWO = 8'h7f;
   localparam logic [7:0] RST_CTL_THREE = 8'hc0;
   localparam logic [1:0] RST_T0_CTL = 2'h0;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int RESET_CAUSE_AND_PRIORITY_CTRL_PRIORITY_LEVELS_ENABLE = 7;
   localparam int RESET_CAUSE_AND_PRIORITY_CTRL_RI = 4;
   localparam int RESET_CAUSE_AND_PRIORITY_CTRL_TO = 3;
   localparam int RESET_CAUSE_AND_PRIORITY_CTRL_PD = 2;
   localparam int MAIN_GIE = 7;
   localparam int MAIN_PERIPH_GROUP_ENABLE = 6;
   localparam int MAIN_T0E = 5;
   localparam int MAIN_INT0E = 4;
   localparam int MAIN_RBE = 3;
   localparam int MAIN_T0F = 2;
   localparam int MAIN_INT0F = 1;
   localparam int MAIN_RBF = 0;
   localparam int CTL2_EDGE_LSB = 3;
   localparam int CTL2_T0P = 2;
   localparam int CTL2_INT3P = 1;
   localparam int CTL2_RBP = 0;
   localparam int CTL3_INT2P = 7;
   localparam int CTL3_INT1P = 6;
   localparam int CTL3_EN_LSB = 3;
   localparam int CTL3_FLAG_LSB = 0;
   localparam int T0_MODE16 = 0;
   localparam int T0_RUN = 1;

   localparam logic [15:0] T0_MAX16 = 16'hffff;
   localparam logic [7:0] T0_MAX8 = 8'hff;

endpackage

//--- core/pipc_sync.sv
// Two-stage synchroniser with one more stage kept for edge detection
`timescale 1ns/1ps
module pipc_sync #(
   parameter int WIDTH = 4
) (
   input logic clock_in,              // Core clock
   input logic srst_in,               // Synchronous reset
   input logic [WIDTH-1:0] async_in,  // Asynchronous pin levels
   output logic [WIDTH-1:0] level_out, // Synchronised level
   output logic [WIDTH-1:0] prev_out   // Level one cycle earlier
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] prev_q;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         meta_q <= '0;
         level_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_in;
         level_q <= meta_q;
         prev_q <= level_q;
      end
   end

   assign level_out = level_q;
   assign prev_out = prev_q;

endmodule

//--- core/pipc_timer_zero.sv
// Timer-zero counter with 8-bit or 16-bit overflow detection
`timescale 1ns/1ps
module pipc_timer_zero (
   input logic clock_in,          // Core clock
   input logic srst_in,           // Synchronous reset
   input logic run_in,            // Count enable
   input logic mode16_in,         // 1 = 16-bit mode, 0 = 8-bit mode
   input logic load_in,           // Load strobe
   input logic [15:0] load_val_in, // Value to load
   output logic [15:0] count_out, // Current count
   output logic ovf_out           // One-cycle overflow pulse
);

   logic [15:0] count_q;
   logic ovf_q;
   logic wrap;

   always_comb begin
      if (mode16_in) begin
         wrap = (count_q == pipc_pkg::T0_MAX16);
      end else begin
         wrap = (count_q[7:0] == pipc_pkg::T0_MAX8);
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         count_q <= '0;
         ovf_q <= 1'b0;
      end else if (load_in) begin
         count_q <= load_val_in;
         ovf_q <= 1'b0;
      end else if (run_in) begin
         if (mode16_in) begin
            count_q <= count_q + 16'h0001;
         end else begin
            count_q[7:0] <= count_q[7:0] + 8'h01;
         end
         ovf_q <= wrap;
      end else begin
         ovf_q <= 1'b0;
      end
   end

   assign count_out = count_q;
   assign ovf_out = ovf_q;

endmodule

//--- bench/pipc_core_model.sv
// Core model that takes each new interrupt request
`timescale 1ns/1ps
module pipc_core_model (
   input wire logic clock_in, // Core clock
   input wire logic srst_in, // Reset
   input wire logic irq_in, // Any request level
   output logic ack_out, // Take pulse
   output logic [20:0] pc_out, // Return address
   output logic [23:0] ctx_out // Working, status, bank
);
   logic prev_q;
   assign pc_out = 21'h12345;
   assign ctx_out = 24'h5a3c0f;
   // Take only on a new request so one push follows each request
   always_ff @(posedge clock_in) begin
      prev_q <= srst_in ? 1'b0 : irq_in;
      ack_out <= !srst_in && irq_in && !prev_q;
   end
endmodule

//--- bench/peripheral_interrupt_priority_ctrl_tb.sv
// Register and routing tests of the interrupt priority controller
`timescale 1ns/1ps
`define CHK(a, b) n_compared++; if ((a) !== (b)) begin err_total++; $display("unexpected %0t %h %h", $time, a, b); end
module peripheral_interrupt_priority_ctrl_tb;
   logic clock_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0, pready, perr, ack;
   logic re, wk, slp = 0;
   logic [2:0] ev = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [7:0] fl1 = 0, fl2 = 0, fl3 = 0, en1 = 0, w, s, b;
   logic [3:0] pin = 0, pb = 0;
   logic ih, il, push;
   logic [20:0] pc, spc;
   logic [23:0] ctx;
   int err_total = 0, n_compared = 0, k;
   logic [11:0] offs [9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018,
      12'h01c, 12'h020};
   logic [7:0] rsv [9] = '{8'h00, 8'h00, 8'hff, 8'h5f, 8'h3f, 8'h1c, 8'h00, 8'h7f, 8'hc0};
   always #2.5 clock_in = !clock_in;
   pipc_core_model core (.clock_in(clock_in), .srst_in(srst_in), .irq_in(ih | il),
      .ack_out(ack), .pc_out(pc), .ctx_out(ctx));
   pipc_ctrl dut (.clock_in(clock_in), .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(perr), .periph_flag_one_in(fl1),
      .periph_flag_two_in(fl2), .periph_flag_three_in(fl3), .periph_enable_one_in(en1),
      .ext_pin_in(pin), .portb_high_in(pb), .sleep_in(slp), .reset_instr_evt_in(ev[2]),
      .watchdog_evt_in(ev[1]), .power_down_evt_in(ev[0]), .irq_ack_in(ack), .ret_pc_in(pc),
      .working_in(ctx[23:16]), .status_in(ctx[15:8]), .bank_in(ctx[7:0]), .irq_high_out(ih),
      .irq_low_out(il), .wake_out(wk), .stack_push_out(push), .stack_pc_out(spc),
      .fast_working_out(w), .fast_status_out(s), .fast_bank_out(b));
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock_in);
      penable <= 1;
      for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clock_in);
      if (k == 20) begin err_total++; end_of_test(); end
      r = prdata;
      re = perr;
      psel <= 0; penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(0, a, 0);
      `CHK(r, {24'h0, e})
   endtask
   task automatic wt(input int lvl, input logic e);
      for (k = 0; k < 12 && (lvl == 2 ? wk : lvl ? il : ih) !== e; k++) @(posedge clock_in);
      `CHK((lvl == 2 ? wk : lvl ? il : ih), e)
   endtask
   initial begin
      repeat (6) @(posedge clock_in);
      srst_in <= 0;
      foreach (offs[i]) rd(offs[i], rsv[i]);
      apb(1, 12'h000, 32'hff); rd(12'h000, 8'h5f);
      apb(1, 12'h004, 32'hff); rd(12'h004, 8'h3f);
      apb(1, 12'h014, 32'hff); rd(12'h014, 8'h9f);
      apb(0, 12'h100, 0);
      `CHK(re, 1'b1)
      `CHK(r, 32'h0)
      apb(1, 12'h018, 32'hc0);
      fl2 <= 8'h40;
      wt(0, 1'b1);
      for (k = 0; k < 10 && push !== 1'b1; k++) @(posedge clock_in);
      `CHK(push, 1'b1)
      `CHK({spc, w, s, b}, {21'h12345, 24'h5a3c0f})
      apb(1, 12'h00c, 32'h0);
      wt(1, 1'b1); wt(0, 1'b0);
      apb(1, 12'h014, 32'h13);
      wt(0, 1'b1); wt(1, 1'b0);
      apb(1, 12'h018, 32'h80);
      wt(0, 1'b0);
      fl2 <= 0;
      apb(1, 12'h014, 32'h80);
      apb(1, 12'h018, 32'h90);
      slp <= 1;
      pin <= 4'h1;
      wt(0, 1'b1); rd(12'h018, 8'h92);
      wt(2, 1'b1);
      apb(1, 12'h018, 32'h88);
      wt(0, 1'b0); wt(2, 1'b0);
      pb <= 4'h2;
      wt(0, 1'b1); rd(12'h018, 8'h89);
      apb(1, 12'h028, 32'hf0);
      apb(1, 12'h024, 32'h2);
      repeat (20) @(posedge clock_in);
      rd(12'h018, 8'h8d);
      ev <= 3'h7;
      @(posedge clock_in);
      ev <= 3'h0;
      rd(12'h014, 8'h80);
      end_of_test();
   end
endmodule
